// ### inc/sss_pkg.sv
// constants, layouts and types of the servo sequence supervisor
//
// Notes on behaviour
// - in-position while |deviation| within completion range
// - zero-speed warning when |speed| at/below threshold
// - speed mode: rotation detect above speed threshold
// - overflow alarm when |deviation| exceeds level times 256
// - overflow alarm enable: 0 enables, 1 suppresses
// - travel inhibit stops motor per selection 0..2
// - 0: inhibited-direction torque off, brake; 1: inhibited-direction torque off, coast
// - 2: servo lock, or zero speed command
// - alarm stop: decel and after-stop per setting
// - alarm clears deviation counter, always
package sss_pkg;

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 32;

   localparam logic [7:0]  OFS_POS_RANGE   = 8'h00;
   localparam logic [7:0]  OFS_ZERO_SPEED  = 8'h04;
   localparam logic [7:0]  OFS_ROT_SPEED   = 8'h08;
   localparam logic [7:0]  OFS_OVF_LEVEL   = 8'h0c;
   localparam logic [7:0]  OFS_OVF_DISABLE = 8'h10;
   localparam logic [7:0]  OFS_PROH_STOP   = 8'h14;
   localparam logic [7:0]  OFS_ALARM_STOP  = 8'h18;
   localparam logic [7:0]  OFS_CONTROL     = 8'h1c;
   localparam logic [7:0]  OFS_STATUS      = 8'h20;
   localparam logic [7:0]  OFS_DEVIATION   = 8'h24;
   localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h28;
   localparam logic [7:0]  OFS_IRQ_MASK    = 8'h2c;

   // ----------------------------------------------------------------
   // values after reset
   // ----------------------------------------------------------------
   localparam logic [14:0] RST_POS_RANGE   = 15'h0019;
   localparam logic [14:0] RST_ZERO_SPEED  = 15'h0014;
   localparam logic [14:0] RST_ROT_SPEED   = 15'h0032;
   localparam logic [14:0] RST_OVF_LEVEL   = 15'h0064;
   localparam logic        RST_OVF_DISABLE = 1'b0;
   localparam logic [1:0]  RST_PROH_STOP   = 2'h0;
   localparam logic [1:0]  RST_ALARM_STOP  = 2'h0;
   localparam logic [1:0]  PROH_STOP_MAX   = 2'h2;
   localparam logic [4:0]  RST_IRQ_MASK    = 5'h00;

   // overflow level unit is 256 pulses
   localparam int          OVF_SHIFT       = 8;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int          CTRL_SPEED_MODE = 0;
   localparam int          CTRL_ALARM_CLR  = 1;

   localparam int          IRQ_ALARM       = 0;
   localparam int          IRQ_FWD_INH     = 1;
   localparam int          IRQ_REV_INH     = 2;
   localparam int          IRQ_ZERO_SPEED  = 3;
   localparam int          IRQ_IN_POS      = 4;
   localparam int          IRQ_W           = 5;

   // pin synchroniser: forward inhibit, reverse inhibit, alarm
   localparam int          SYNC_W          = 3;
   localparam int          PIN_FWD         = 0;
   localparam int          PIN_REV         = 1;
   localparam int          PIN_ALM         = 2;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_RUN,
      ST_DECEL,
      ST_STOPPED
   } sss_alarm_e;

   typedef struct packed {
      logic torque_fwd_en;
      logic torque_rev_en;
      logic dyn_brake;
      logic coast;
      logic servo_free;
      logic servo_lock;
      logic zero_speed_cmd;
      logic dev_clear;
   } sss_drive_s;

   typedef struct packed {
      logic in_position_output;
      logic zero_speed_warning;
      logic rotation_detect_output;
      logic alarm_output;
   } sss_status_s;

endpackage

// ### core/sss_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module sss_pin_sync (
   input  wire logic                      clk_sys,
   input  wire logic                      resetn,
   input  wire logic [sss_pkg::SYNC_W-1:0] pin_in,
   output logic      [sss_pkg::SYNC_W-1:0] level
);

   logic [sss_pkg::SYNC_W-1:0] stage1;
   logic [sss_pkg::SYNC_W-1:0] stage2;
   logic [sss_pkg::SYNC_W-1:0] stage3;
   wire  [sss_pkg::SYNC_W-1:0] differ;
   wire  [sss_pkg::SYNC_W-1:0] next_level;

   // a change counts only once stages two and three agree
   assign differ     = stage2 ^ stage3;
   assign next_level = (stage2 & ~differ) | (level & differ);

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
         level  <= '0;
      end else begin
         stage1 <= pin_in;
         stage2 <= stage1;
         stage3 <= stage2;
         level  <= next_level;
      end
   end

endmodule

// ### core/sss_supervisor.sv
// servo sequence supervisor: thresholds, overflow alarm, stop selection
`timescale 1ns/1ps
module sss_supervisor (
   input  wire logic                        clk_sys,
   input  wire logic                        resetn,
   input  wire logic [sss_pkg::ADDR_W-1:0]  reg_addr,
   input  wire logic [sss_pkg::DATA_W-1:0]  reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic      [sss_pkg::DATA_W-1:0]  reg_rdata,
   input  wire logic signed [31:0]          deviation_count,
   input  wire logic signed [15:0]          motor_speed,
   input  wire logic                        forward_travel_inhibit,
   input  wire logic                        reverse_travel_inhibit,
   input  wire logic                        external_alarm,
   output sss_pkg::sss_status_s             host_status,
   output sss_pkg::sss_drive_s              drive_cmd,
   output logic                             irq
);

   // ----
   // helpers
   // ----
   function automatic logic [15:0] abs_speed(input logic signed [15:0] v);
      abs_speed = v[15] ? 16'(-v) : 16'(v);
   endfunction

   function automatic logic [31:0] abs_dev(input logic signed [31:0] v);
      abs_dev = v[31] ? 32'(-v) : 32'(v);
   endfunction

   // ----
   // configuration registers
   // ----
   logic [14:0]               pos_range;
   logic [14:0]               zero_speed_thr;
   logic [14:0]               rot_speed_thr;
   logic [14:0]               ovf_level;
   logic                      ovf_disable;
   logic [1:0]                proh_stop_sel;
   logic [1:0]                alarm_stop_sel;
   logic                      speed_mode;
   logic [sss_pkg::IRQ_W-1:0] irq_status;
   logic [sss_pkg::IRQ_W-1:0] irq_mask;

   // ----
   // state
   // ----
   sss_pkg::sss_alarm_e        alarm_state;
   sss_pkg::sss_alarm_e        next_alarm_state;
   logic [sss_pkg::SYNC_W-1:0] pin_level;
   logic [sss_pkg::SYNC_W-1:0] pin_level_d;
   logic                       zero_warn_d;
   logic                       in_pos_d;

   // ----
   // pin synchronisers
   // ----
   wire [sss_pkg::SYNC_W-1:0] pin_raw;

   assign pin_raw[sss_pkg::PIN_FWD] = forward_travel_inhibit;
   assign pin_raw[sss_pkg::PIN_REV] = reverse_travel_inhibit;
   assign pin_raw[sss_pkg::PIN_ALM] = external_alarm;

   sss_pin_sync u_sync (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .pin_in  (pin_raw),
      .level   (pin_level)
   );

   wire fwd_inh = pin_level[sss_pkg::PIN_FWD];
   wire rev_inh = pin_level[sss_pkg::PIN_REV];
   wire ext_alm = pin_level[sss_pkg::PIN_ALM];

   // ----
   // comparisons
   // ----
   wire [15:0] speed_mag = abs_speed(motor_speed);
   wire [31:0] dev_mag   = abs_dev(deviation_count);
   wire [31:0] ovf_limit = {9'h000, ovf_level, 8'h00};

   wire in_pos_now   = dev_mag <= {17'h00000, pos_range};
   wire zero_warn    = speed_mag <= {1'b0, zero_speed_thr};
   wire rotating     = speed_mode && (speed_mag > {1'b0, rot_speed_thr});
   wire ovf_detect   = (dev_mag > ovf_limit) && !ovf_disable;
   wire alarm_cause  = ovf_detect || ext_alm;
   wire alarm_active = alarm_state != sss_pkg::ST_RUN;

   // ----
   // bus decode
   // ----
   wire wr_pos   = reg_wr && (reg_addr == sss_pkg::OFS_POS_RANGE);
   wire wr_zero  = reg_wr && (reg_addr == sss_pkg::OFS_ZERO_SPEED);
   wire wr_rot   = reg_wr && (reg_addr == sss_pkg::OFS_ROT_SPEED);
   wire wr_ovf   = reg_wr && (reg_addr == sss_pkg::OFS_OVF_LEVEL);
   wire wr_ovfd  = reg_wr && (reg_addr == sss_pkg::OFS_OVF_DISABLE);
   wire wr_proh  = reg_wr && (reg_addr == sss_pkg::OFS_PROH_STOP);
   wire wr_alms  = reg_wr && (reg_addr == sss_pkg::OFS_ALARM_STOP);
   wire wr_ctrl  = reg_wr && (reg_addr == sss_pkg::OFS_CONTROL);
   wire wr_istat = reg_wr && (reg_addr == sss_pkg::OFS_IRQ_STATUS);
   wire wr_imask = reg_wr && (reg_addr == sss_pkg::OFS_IRQ_MASK);

   // out-of-range stop selections are ignored, keeping the old value
   wire proh_ok  = reg_wdata[1:0] <= sss_pkg::PROH_STOP_MAX;
   wire alarm_clr_req = wr_ctrl && reg_wdata[sss_pkg::CTRL_ALARM_CLR];

   wire [sss_pkg::DATA_W-1:0] status_word = {
      25'h0000000,
      rev_inh,
      fwd_inh,
      alarm_active,
      host_status.alarm_output,
      host_status.rotation_detect_output,
      host_status.zero_speed_warning,
      host_status.in_position_output
   };

   logic [sss_pkg::DATA_W-1:0] rd_mux;

   always_comb begin
      case (reg_addr)
         sss_pkg::OFS_POS_RANGE:   rd_mux = {17'h00000, pos_range};
         sss_pkg::OFS_ZERO_SPEED:  rd_mux = {17'h00000, zero_speed_thr};
         sss_pkg::OFS_ROT_SPEED:   rd_mux = {17'h00000, rot_speed_thr};
         sss_pkg::OFS_OVF_LEVEL:   rd_mux = {17'h00000, ovf_level};
         sss_pkg::OFS_OVF_DISABLE: rd_mux = {31'h00000000, ovf_disable};
         sss_pkg::OFS_PROH_STOP:   rd_mux = {30'h00000000, proh_stop_sel};
         sss_pkg::OFS_ALARM_STOP:  rd_mux = {30'h00000000, alarm_stop_sel};
         sss_pkg::OFS_CONTROL:     rd_mux = {31'h00000000, speed_mode};
         sss_pkg::OFS_STATUS:      rd_mux = status_word;
         sss_pkg::OFS_DEVIATION:   rd_mux = deviation_count;
         sss_pkg::OFS_IRQ_STATUS:  rd_mux = {27'h0000000, irq_status};
         sss_pkg::OFS_IRQ_MASK:    rd_mux = {27'h0000000, irq_mask};
         default:                  rd_mux = '0;
      endcase
   end

   wire [sss_pkg::DATA_W-1:0] next_rdata = reg_rd ? rd_mux : '0;

   // ----
   // alarm stop sequence
   // ----
   // motor counts as stopped once the zero-speed comparison holds
   always_comb begin
      next_alarm_state = alarm_state;
      case (alarm_state)
         sss_pkg::ST_RUN: begin
            if (alarm_cause) begin
               next_alarm_state = sss_pkg::ST_DECEL;
            end
         end
         sss_pkg::ST_DECEL: begin
            if (zero_warn) begin
               next_alarm_state = sss_pkg::ST_STOPPED;
            end
         end
         sss_pkg::ST_STOPPED: begin
            // a pending cause keeps the alarm: set wins over clear
            if (alarm_clr_req && !alarm_cause) begin
               next_alarm_state = sss_pkg::ST_RUN;
            end
         end
         default: begin
            next_alarm_state = sss_pkg::ST_RUN;
         end
      endcase
   end

   // ----
   // drive command
   // ----
   wire alm_decel_brake = !alarm_stop_sel[0];  // 0,2 brake; 1,3 coast
   wire alm_stop_brake  = !alarm_stop_sel[1];  // 0,1 brake; 2,3 free
   wire proh_any        = fwd_inh || rev_inh;

   sss_pkg::sss_drive_s next_drive;

   always_comb begin
      next_drive = '0;
      next_drive.torque_fwd_en = 1'b1;
      next_drive.torque_rev_en = 1'b1;
      case (alarm_state)
         sss_pkg::ST_DECEL: begin
            next_drive.torque_fwd_en = 1'b0;
            next_drive.torque_rev_en = 1'b0;
            next_drive.dyn_brake     = alm_decel_brake;
            next_drive.coast         = !alm_decel_brake;
            next_drive.dev_clear     = 1'b1;
         end
         sss_pkg::ST_STOPPED: begin
            next_drive.torque_fwd_en = 1'b0;
            next_drive.torque_rev_en = 1'b0;
            next_drive.dyn_brake     = alm_stop_brake;
            next_drive.servo_free    = !alm_stop_brake;
            next_drive.dev_clear     = 1'b1;
         end
         default: begin
            if (proh_any) begin
               case (proh_stop_sel)
                  2'h0: begin
                     next_drive.torque_fwd_en = !fwd_inh;
                     next_drive.torque_rev_en = !rev_inh;
                     next_drive.dyn_brake     = 1'b1;
                  end
                  2'h1: begin
                     next_drive.torque_fwd_en = !fwd_inh;
                     next_drive.torque_rev_en = !rev_inh;
                     next_drive.coast         = 1'b1;
                  end
                  2'h2: begin
                     next_drive.servo_lock     = !speed_mode;
                     next_drive.zero_speed_cmd = speed_mode;
                  end
                  default: begin
                     next_drive.dyn_brake = 1'b1;
                  end
               endcase
            end
         end
      endcase
   end

   sss_pkg::sss_status_s next_status;

   always_comb begin
      next_status.in_position_output     = in_pos_now;
      next_status.zero_speed_warning     = zero_warn;
      next_status.rotation_detect_output = rotating;
      next_status.alarm_output           = next_alarm_state != sss_pkg::ST_RUN;
   end

   // ----
   // interrupt events
   // ----
   wire [sss_pkg::IRQ_W-1:0] irq_event = {
      in_pos_now && !in_pos_d,
      zero_warn && !zero_warn_d,
      rev_inh && !pin_level_d[sss_pkg::PIN_REV],
      fwd_inh && !pin_level_d[sss_pkg::PIN_FWD],
      alarm_cause && !alarm_active
   };

   wire [sss_pkg::IRQ_W-1:0] irq_clear = wr_istat ? reg_wdata[sss_pkg::IRQ_W-1:0] : '0;
   // set wins over a clear in the same cycle
   wire [sss_pkg::IRQ_W-1:0] next_irq_status = (irq_status & ~irq_clear) | irq_event;
   wire [sss_pkg::IRQ_W-1:0] next_irq_mask   = wr_imask ? reg_wdata[sss_pkg::IRQ_W-1:0] : irq_mask;
   wire                      next_irq        = |(next_irq_status & next_irq_mask);

   // ----
   // configuration storage
   // ----
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pos_range      <= sss_pkg::RST_POS_RANGE;
         zero_speed_thr <= sss_pkg::RST_ZERO_SPEED;
         rot_speed_thr  <= sss_pkg::RST_ROT_SPEED;
         ovf_level      <= sss_pkg::RST_OVF_LEVEL;
         ovf_disable    <= sss_pkg::RST_OVF_DISABLE;
         proh_stop_sel  <= sss_pkg::RST_PROH_STOP;
         alarm_stop_sel <= sss_pkg::RST_ALARM_STOP;
         speed_mode     <= 1'b0;
         irq_mask       <= sss_pkg::RST_IRQ_MASK;
      end else begin
         if (wr_pos)  pos_range      <= reg_wdata[14:0];
         if (wr_zero) zero_speed_thr <= reg_wdata[14:0];
         if (wr_rot)  rot_speed_thr  <= reg_wdata[14:0];
         if (wr_ovf)  ovf_level      <= reg_wdata[14:0];
         if (wr_ovfd) ovf_disable    <= reg_wdata[0];
         if (wr_proh && proh_ok) proh_stop_sel <= reg_wdata[1:0];
         if (wr_alms) alarm_stop_sel <= reg_wdata[1:0];
         if (wr_ctrl) speed_mode     <= reg_wdata[sss_pkg::CTRL_SPEED_MODE];
         irq_mask <= next_irq_mask;
      end
   end

   // ----
   // state and outputs
   // ----
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         alarm_state <= sss_pkg::ST_RUN;
         pin_level_d <= '0;
         zero_warn_d <= 1'b0;
         in_pos_d    <= 1'b0;
         irq_status  <= '0;
         irq         <= 1'b0;
         reg_rdata   <= '0;
         host_status <= '0;
         drive_cmd   <= '0;
      end else begin
         alarm_state <= next_alarm_state;
         pin_level_d <= pin_level;
         zero_warn_d <= zero_warn;
         in_pos_d    <= in_pos_now;
         irq_status  <= next_irq_status;
         irq         <= next_irq;
         reg_rdata   <= next_rdata;
         host_status <= next_status;
         drive_cmd   <= next_drive;
      end
   end

endmodule

// ### verif/sss_motor_model.sv
// behavioural power stage and deviation source on the drive side
`timescale 1ns/1ps
module sss_motor_model (
   input  wire logic                clk_sys,
   input  wire logic                resetn,
   input  wire sss_pkg::sss_drive_s drive_cmd,
   input  wire logic signed [15:0]  speed_tgt,
   input  wire logic signed [31:0]  dev_tgt,
   output logic signed [15:0]       motor_speed,
   output logic signed [31:0]       deviation_count
);
   // ----
   // rotor
   // ----
   // no torque: rotor winds down so the stop phase ends by itself;
   // limitation: a reverse speed drops straight to zero
   wire no_torque = !drive_cmd.torque_fwd_en && !drive_cmd.torque_rev_en;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         motor_speed     <= 16'sh0;
         deviation_count <= 32'sh0;
      end else begin
         deviation_count <= drive_cmd.dev_clear ? 32'sh0 : dev_tgt;
         if (!no_torque)
            motor_speed <= speed_tgt;
         else if (motor_speed > 16'sh64)
            motor_speed <= motor_speed - 16'sh64;
         else
            motor_speed <= 16'sh0;
      end
   end
endmodule

// ### verif/sss_supervisor_checker.sv
// concurrent checks on the supervisor's ports
`timescale 1ns/1ps
module sss_supervisor_checker (
   input wire logic                       clk_sys,
   input wire logic                       resetn,
   input wire logic [sss_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [sss_pkg::DATA_W-1:0] reg_wdata,
   input wire logic                       reg_wr,
   input wire logic                       reg_rd,
   input wire logic [sss_pkg::DATA_W-1:0] reg_rdata,
   input wire logic signed [31:0]         deviation_count,
   input wire logic signed [15:0]         motor_speed,
   input wire logic                       forward_travel_inhibit,
   input wire logic                       reverse_travel_inhibit,
   input wire logic                       external_alarm,
   input wire sss_pkg::sss_status_s       host_status,
   input wire sss_pkg::sss_drive_s        drive_cmd,
   input wire logic                       irq
);
   // ----
   // threshold mirrors
   // ----
   logic [14:0] thr_zero;
   logic [14:0] pos_rng;
   wire  [15:0] spd_abs = motor_speed[15] ? 16'(-motor_speed) : 16'(motor_speed);
   wire  [31:0] dev_abs = deviation_count[31] ? 32'(-deviation_count) : 32'(deviation_count);
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         thr_zero <= sss_pkg::RST_ZERO_SPEED;
         pos_rng  <= sss_pkg::RST_POS_RANGE;
      end else if (reg_wr) begin
         if (reg_addr == sss_pkg::OFS_ZERO_SPEED) thr_zero <= reg_wdata[14:0];
         if (reg_addr == sss_pkg::OFS_POS_RANGE) pos_rng <= reg_wdata[14:0];
      end
   end
   // ----
   // properties
   // ----
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   sequence alarm_held;
      host_status.alarm_output && $past(host_status.alarm_output);
   endsequence
   a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data not zero outside read answer");
   a_zero_speed_warn: assert property ($past(resetn) |->
      host_status.zero_speed_warning == ($past(spd_abs) <= $past(thr_zero)))
      else $error("zero speed warning wrong");
   a_in_position: assert property ($past(resetn) |->
      host_status.in_position_output == ($past(dev_abs) <= $past(pos_rng)))
      else $error("in position output wrong");
   a_run_keeps_torque: assert property (
      (!forward_travel_inhibit && !reverse_travel_inhibit && !host_status.alarm_output) [*7]
      |-> drive_cmd.torque_fwd_en && drive_cmd.torque_rev_en && !drive_cmd.dyn_brake)
      else $error("torque removed without cause");
   a_alarm_torque_off: assert property (alarm_held |->
      !drive_cmd.torque_fwd_en && !drive_cmd.torque_rev_en)
      else $error("torque on during alarm");
   a_alarm_dev_clear: assert property ($rose(host_status.alarm_output) |=>
      drive_cmd.dev_clear [*2])
      else $error("deviation not cleared on alarm");
   a_alarm_one_stop: assert property (alarm_held |->
      $onehot({drive_cmd.dyn_brake, drive_cmd.coast, drive_cmd.servo_free}))
      else $error("alarm stop mode not single");
   a_lock_excl: assert property (drive_cmd.servo_lock |->
      !drive_cmd.zero_speed_cmd && !drive_cmd.dyn_brake)
      else $error("servo lock mixed with other stop");
   c_alarm: cover property ($rose(host_status.alarm_output));
   c_lock: cover property (drive_cmd.servo_lock);
   c_zero_cmd: cover property (drive_cmd.zero_speed_cmd);
   c_free: cover property (drive_cmd.servo_free);
endmodule

bind sss_supervisor sss_supervisor_checker chk_i (
   .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .deviation_count(deviation_count),
   .motor_speed(motor_speed), .forward_travel_inhibit(forward_travel_inhibit),
   .reverse_travel_inhibit(reverse_travel_inhibit), .external_alarm(external_alarm),
   .host_status(host_status), .drive_cmd(drive_cmd), .irq(irq)
);

// ### verif/sss_supervisor_test.sv
// self-checking testbench of the servo sequence supervisor
`timescale 1ns/1ps
module servo_sequence_supervisor_test;
   logic                clk_sys = 1'b0;
   logic                resetn = 1'b0;
   logic [7:0]          reg_addr = 8'h0;
   logic [31:0]         reg_wdata = 32'h0;
   logic                reg_wr = 1'b0;
   logic                reg_rd = 1'b0;
   logic [31:0]         reg_rdata;
   logic signed [15:0]  speed_tgt = 16'sh0;
   logic signed [31:0]  dev_tgt = 32'sh0;
   logic signed [15:0]  motor_speed;
   logic signed [31:0]  deviation_count;
   logic                forward_travel_inhibit = 1'b0;
   logic                reverse_travel_inhibit = 1'b0;
   logic                external_alarm = 1'b0;
   sss_pkg::sss_status_s host_status;
   sss_pkg::sss_drive_s  drive_cmd;
   logic                irq;
   int                  fail_count = 0;
   int                  checked = 0;
   int                  cycles = 0;

   sss_supervisor dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .deviation_count(deviation_count), .motor_speed(motor_speed),
      .forward_travel_inhibit(forward_travel_inhibit), .reverse_travel_inhibit(reverse_travel_inhibit),
      .external_alarm(external_alarm), .host_status(host_status), .drive_cmd(drive_cmd), .irq(irq));
   sss_motor_model motor (.clk_sys(clk_sys), .resetn(resetn), .drive_cmd(drive_cmd),
      .speed_tgt(speed_tgt), .dev_tgt(dev_tgt), .motor_speed(motor_speed),
      .deviation_count(deviation_count));

   always #12.5 clk_sys = ~clk_sys;
   // ----
   // helpers
   // ----
   task automatic wrap_up;
      $display("checks %0d errors %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // long enough for all scenarios, short enough to catch a hang
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         wrap_up;
      end
   end
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         $display("Error %s expected %h seen %h", name, exp, seen);
         fail_count++;
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // ----
   // scenarios
   // ----
   task automatic t_reset;
      logic [7:0]  a [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h2c, 8'h30};
      logic [31:0] e [9] = '{32'h19, 32'h14, 32'h32, 32'h64, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
      logic [31:0] d;
      cyc(8);
      chk("status", 32'(host_status), 32'hc);
      chk("drive", 32'(drive_cmd), 32'hc0);
      for (int i = 0; i < 9; i++) begin
         rd(a[i], d);
         chk("reg", d, e[i]);
      end
   endtask
   task automatic t_thresh;
      logic [15:0] s [4] = '{16'hffec, 16'hffeb, 16'h0014, 16'h0015};
      logic [31:0] v [4] = '{32'hffffffe7, 32'hffffffe6, 32'h19, 32'h1a};
      for (int i = 0; i < 4; i++) begin
         speed_tgt <= s[i];
         dev_tgt   <= v[i];
         cyc(4);
         chk("zero_warn", 32'(host_status.zero_speed_warning), 32'(i % 2 == 0));
         chk("in_pos", 32'(host_status.in_position_output), 32'(i % 2 == 0));
      end
      wr(sss_pkg::OFS_ZERO_SPEED, 32'h64);
      speed_tgt <= 16'hff9c;
      cyc(4);
      chk("zero_warn", 32'(host_status.zero_speed_warning), 32'h1);
      wr(sss_pkg::OFS_ZERO_SPEED, 32'h14);
   endtask
   task automatic t_rotate;
      logic [15:0] s [4] = '{16'h0033, 16'h0032, 16'hffcd, 16'h0033};
      for (int i = 0; i < 4; i++) begin
         wr(sss_pkg::OFS_CONTROL, 32'(i < 3));
         speed_tgt <= s[i];
         cyc(4);
         chk("rotate", 32'(host_status.rotation_detect_output), 32'(i % 2 == 0 && i < 3));
      end
      wr(sss_pkg::OFS_CONTROL, 32'h0);
      speed_tgt <= 16'sh0;
      dev_tgt   <= 32'sh0;
   endtask
   task automatic t_inhibit;
      logic [7:0]  e [3] = '{8'h60, 8'h50, 8'h04};
      logic [7:0]  m [3] = '{8'hf0, 8'hf0, 8'h06};
      logic [31:0] d;
      for (int i = 0; i < 4; i++) begin
         wr(sss_pkg::OFS_PROH_STOP, 32'(i < 3 ? i : 2));
         wr(sss_pkg::OFS_CONTROL, 32'(i == 3));
         forward_travel_inhibit <= 1'b1;
         cyc(8);
         if (i < 3)
            chk("inhibit", 32'(drive_cmd & m[i]), 32'(e[i]));
         else
            chk("inhibit", 32'(drive_cmd & 8'h06), 32'h2);
         forward_travel_inhibit <= 1'b0;
         cyc(8);
      end
      wr(sss_pkg::OFS_CONTROL, 32'h0);
      wr(sss_pkg::OFS_PROH_STOP, 32'h3);
      rd(sss_pkg::OFS_PROH_STOP, d);
      chk("proh_sel", d, 32'h2);
      wr(sss_pkg::OFS_PROH_STOP, 32'h0);
      reverse_travel_inhibit <= 1'b1;
      cyc(8);
      chk("inhibit", 32'(drive_cmd & 8'hf0), 32'ha0);
      reverse_travel_inhibit <= 1'b0;
      cyc(8);
   endtask
   task automatic t_irq;
      wr(sss_pkg::OFS_IRQ_STATUS, 32'h1f);
      wr(sss_pkg::OFS_IRQ_MASK, 32'h2);
      forward_travel_inhibit <= 1'b1;
      cyc(8);
      chk("irq", 32'(irq), 32'h1);
      wr(sss_pkg::OFS_IRQ_MASK, 32'h0);
      cyc(2);
      chk("irq", 32'(irq), 32'h0);
      wr(sss_pkg::OFS_IRQ_MASK, 32'h2);
      cyc(2);
      chk("irq", 32'(irq), 32'h1);
      wr(sss_pkg::OFS_IRQ_STATUS, 32'h2);
      cyc(2);
      chk("irq", 32'(irq), 32'h0);
      forward_travel_inhibit <= 1'b0;
      cyc(8);
   endtask
   task automatic t_ovf;
      dev_tgt <= 32'sh6400;
      cyc(6);
      chk("alarm", 32'(host_status.alarm_output), 32'h0);
      wr(sss_pkg::OFS_OVF_DISABLE, 32'h1);
      dev_tgt <= 32'sh6401;
      cyc(6);
      chk("alarm", 32'(host_status.alarm_output), 32'h0);
      dev_tgt <= 32'sh0;
      wr(sss_pkg::OFS_OVF_DISABLE, 32'h0);
      cyc(4);
   endtask
   task automatic t_alarm;
      logic [31:0] d;
      logic        b;
      for (int s = 0; s < 4; s++) begin
         wr(sss_pkg::OFS_ALARM_STOP, 32'(s));
         speed_tgt <= 16'sh3e8;
         cyc(4);
         if (s == 3)
            external_alarm <= 1'b1;
         else
            dev_tgt <= 32'sh6401;
         cyc(s == 3 ? 8 : 4);
         chk("alarm", 32'(host_status.alarm_output), 32'h1);
         b = (s % 2 == 0);
         chk("decel", 32'(drive_cmd), {24'h0, 2'h0, b, !b, 4'h1});
         dev_tgt        <= 32'sh0;
         external_alarm <= 1'b0;
         cyc(24);
         b = (s < 2);
         chk("stopped", 32'(drive_cmd), {24'h0, 2'h0, b, 1'h0, !b, 3'h1});
         rd(sss_pkg::OFS_DEVIATION, d);
         chk("deviation", d, 32'h0);
         wr(sss_pkg::OFS_CONTROL, 32'h2);
         cyc(3);
         chk("alarm", 32'(host_status.alarm_output), 32'h0);
      end
      speed_tgt <= 16'sh0;
   endtask
   // ----
   // main sequence
   // ----
   initial begin
      repeat (20) @(posedge clk_sys);
      resetn <= 1'b1;
      t_reset;
      t_thresh;
      t_rotate;
      t_inhibit;
      t_irq;
      t_ovf;
      t_alarm;
      wrap_up;
   end
endmodule
